/* File: shared/sse_pkg.sv */
package sse_pkg;

    localparam logic [13:0] SLEEP_CODE = 14'h0063;
    localparam logic [13:0] SUBL_MASK  = 14'h3E00;
    localparam logic [13:0] SUBL_CODE  = 14'h3C00;
    localparam logic [13:0] SUBF_MASK  = 14'h3F00;
    localparam logic [13:0] SUBF_CODE  = 14'h0200;
    localparam int          DEST_BIT   = 7;

    localparam logic [1:0] REG_ACC    = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam logic [1:0] REG_CORE   = 2'h2;

    localparam int STAT_CARRY = 0;
    localparam int STAT_DC    = 1;
    localparam int STAT_ZERO  = 2;
    localparam int STAT_PD    = 3;
    localparam int STAT_TO    = 4;

    localparam logic [7:0] ACC_RESET  = 8'h00;
    localparam logic       FLAG_RESET = 1'b0;
    localparam logic       TO_RESET   = 1'b1;
    localparam logic       PD_RESET   = 1'b1;

    typedef enum logic [1:0] {
        SSE_OP_NONE  = 2'b00,
        SSE_OP_SLEEP = 2'b01,
        SSE_OP_SUBL  = 2'b10,
        SSE_OP_SUBF  = 2'b11
    } sse_op_t;

    typedef enum logic [0:0] {
        SSE_RUN  = 1'b0,
        SSE_HALT = 1'b1
    } sse_state_t;

    typedef struct packed {
        sse_state_t state;
        logic [7:0] acc;
        logic       carry;
        logic       digit_carry_flag;
        logic       zero;
        logic       timeout_flag;
        logic       power_down_flag;
        logic       file_wr;
        logic [6:0] file_addr;
        logic [7:0] file_data;
        logic       wdt_clr;
        logic [7:0] rd_data;
    } sse_regs_t;

    function automatic logic op_match(input logic [13:0] instr, input logic [13:0] mask,
                                      input logic [13:0] code);
        op_match = (instr & mask) == code;
    endfunction

    function automatic logic no_borrow(input logic [7:0] a, input logic [7:0] b);
        no_borrow = a >= b;
    endfunction

endpackage

/* File: src/sse_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module sse_decode (
    input  wire logic [13:0]      instr_i,
    output sse_pkg::sse_op_t      op_o,
    output logic                  dest_file_o,
    output logic [6:0]            file_addr_o,
    output logic [7:0]            literal_o
);

    always_comb begin
        if (instr_i == sse_pkg::SLEEP_CODE) begin
            op_o = sse_pkg::SSE_OP_SLEEP;
        end else if (sse_pkg::op_match(instr_i, sse_pkg::SUBL_MASK, sse_pkg::SUBL_CODE)) begin
            op_o = sse_pkg::SSE_OP_SUBL;
        end else if (sse_pkg::op_match(instr_i, sse_pkg::SUBF_MASK, sse_pkg::SUBF_CODE)) begin
            op_o = sse_pkg::SSE_OP_SUBF;
        end else begin
            op_o = sse_pkg::SSE_OP_NONE;
        end
    end

    assign dest_file_o = instr_i[sse_pkg::DEST_BIT];
    assign file_addr_o = instr_i[6:0];
    assign literal_o   = instr_i[7:0];

endmodule
`default_nettype wire

/* File: src/sse_subtract.sv */
`timescale 1ns/1ps
`default_nettype none
module sse_subtract (
    input  wire logic [7:0] minuend_i,
    input  wire logic [7:0] subtrahend_i,
    output logic [7:0]      diff_o,
    output logic            carry_o,
    output logic            dc_o,
    output logic            zero_o
);

    // Difference wraps modulo 256 by truncation to eight bits.
    assign diff_o  = 8'(minuend_i - subtrahend_i);
    assign carry_o = sse_pkg::no_borrow(minuend_i, subtrahend_i);
    assign dc_o    = sse_pkg::no_borrow({4'h0, minuend_i[3:0]}, {4'h0, subtrahend_i[3:0]});
    assign zero_o  = diff_o == 8'h00;

endmodule
`default_nettype wire

/* File: src/sse_core.sv */
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sse_core (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    input  wire logic        clk_en_i,
    input  wire logic [13:0] instr_i,
    input  wire logic        instr_valid_i,
    output logic             instr_ready_o,
    input  wire logic        wake_i,
    output logic [6:0]       file_rd_addr_o,
    input  wire logic [7:0]  file_rd_data_i,
    output logic             file_wr_o,
    output logic [6:0]       file_wr_addr_o,
    output logic [7:0]       file_wr_data_o,
    output logic             wdt_clear_o,
    output logic             osc_stop_o,
    output logic [7:0]       acc_o,
    output logic             carry_o,
    output logic             digit_carry_flag_o,
    output logic             zero_o,
    output logic             timeout_flag_o,
    output logic             power_down_flag_o,
    input  wire logic [1:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [7:0]       reg_rdata_o
);

    sse_pkg::sse_regs_t q;
    sse_pkg::sse_regs_t next_q;

    sse_pkg::sse_op_t   op;
    logic               dest_file;
    logic [6:0]         file_addr;
    logic [7:0]         literal;
    logic [7:0]         sub_arg;
    logic [7:0]         diff;
    logic               sub_carry;
    logic               sub_dc;
    logic               sub_zero;
    logic               running;
    logic               exec;
    logic               exec_sleep;
    logic               exec_subl;
    logic               exec_subf;
    logic [7:0]         status_byte;

    sse_decode u_decode (
        .instr_i     (instr_i),
        .op_o        (op),
        .dest_file_o (dest_file),
        .file_addr_o (file_addr),
        .literal_o   (literal)
    );

    // The subtracter always takes the accumulator as subtrahend.
    assign sub_arg = (op == sse_pkg::SSE_OP_SUBL) ? literal : file_rd_data_i;

    sse_subtract u_subtract (
        .minuend_i    (sub_arg),
        .subtrahend_i (q.acc),
        .diff_o       (diff),
        .carry_o      (sub_carry),
        .dc_o         (sub_dc),
        .zero_o       (sub_zero)
    );

    assign running    = q.state == sse_pkg::SSE_RUN;
    assign exec       = instr_valid_i && running && clk_en_i;
    assign exec_sleep = exec && (op == sse_pkg::SSE_OP_SLEEP);
    assign exec_subl  = exec && (op == sse_pkg::SSE_OP_SUBL);
    assign exec_subf  = exec && (op == sse_pkg::SSE_OP_SUBF);

    always_comb begin
        status_byte                        = 8'h00;
        status_byte[sse_pkg::STAT_CARRY]   = q.carry;
        status_byte[sse_pkg::STAT_DC]      = q.digit_carry_flag;
        status_byte[sse_pkg::STAT_ZERO]    = q.zero;
        status_byte[sse_pkg::STAT_PD]      = q.power_down_flag;
        status_byte[sse_pkg::STAT_TO]      = q.timeout_flag;
    end

    always_comb begin
        next_q         = q;
        next_q.file_wr = 1'b0;
        next_q.wdt_clr = 1'b0;
        next_q.rd_data = 8'h00;

        // Software access comes first so that an instruction in the same cycle wins.
        if (reg_rd_i) begin
            case (reg_addr_i)
                sse_pkg::REG_ACC: begin
                    next_q.rd_data = q.acc;
                end
                sse_pkg::REG_STATUS: begin
                    next_q.rd_data = status_byte;
                end
                sse_pkg::REG_CORE: begin
                    next_q.rd_data = {7'h00, q.state};
                end
                default: begin
                    next_q.rd_data = 8'h00;
                end
            endcase
        end
        if (reg_wr_i) begin
            case (reg_addr_i)
                sse_pkg::REG_ACC: begin
                    next_q.acc = reg_wdata_i;
                end
                sse_pkg::REG_STATUS: begin
                    next_q.carry            = reg_wdata_i[sse_pkg::STAT_CARRY];
                    next_q.digit_carry_flag = reg_wdata_i[sse_pkg::STAT_DC];
                    next_q.zero             = reg_wdata_i[sse_pkg::STAT_ZERO];
                end
                default: begin
                    next_q.rd_data = next_q.rd_data;
                end
            endcase
        end

        case (q.state)
            sse_pkg::SSE_RUN: begin
                if (instr_valid_i) begin
                    case (op)
                        sse_pkg::SSE_OP_SLEEP: begin
                            next_q.power_down_flag = 1'b0;
                            next_q.timeout_flag    = 1'b1;
                            next_q.wdt_clr         = 1'b1;
                            next_q.state           = sse_pkg::SSE_HALT;
                        end
                        sse_pkg::SSE_OP_SUBL, sse_pkg::SSE_OP_SUBF: begin
                            next_q.carry            = sub_carry;
                            next_q.digit_carry_flag = sub_dc;
                            next_q.zero             = sub_zero;
                            if (op == sse_pkg::SSE_OP_SUBF && dest_file) begin
                                next_q.file_wr   = 1'b1;
                                next_q.file_addr = file_addr;
                                next_q.file_data = diff;
                            end else begin
                                next_q.acc = diff;
                            end
                        end
                        default: begin
                            next_q.state = sse_pkg::SSE_RUN;
                        end
                    endcase
                end
            end
            sse_pkg::SSE_HALT: begin
                // Instructions are ignored until the wake-up input is seen.
                if (wake_i) begin
                    next_q.state = sse_pkg::SSE_RUN;
                end
            end
            default: begin
                next_q.state = sse_pkg::SSE_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            q.state            <= sse_pkg::SSE_RUN;
            q.acc              <= sse_pkg::ACC_RESET;
            q.carry            <= sse_pkg::FLAG_RESET;
            q.digit_carry_flag <= sse_pkg::FLAG_RESET;
            q.zero             <= sse_pkg::FLAG_RESET;
            q.timeout_flag     <= sse_pkg::TO_RESET;
            q.power_down_flag  <= sse_pkg::PD_RESET;
            q.file_wr          <= 1'b0;
            q.file_addr        <= 7'h00;
            q.file_data        <= 8'h00;
            q.wdt_clr          <= 1'b0;
            q.rd_data          <= 8'h00;
        end else if (clk_en_i) begin
            q <= next_q;
        end
    end

    assign instr_ready_o      = running;
    assign file_rd_addr_o     = file_addr;
    assign file_wr_o          = q.file_wr;
    assign file_wr_addr_o     = q.file_addr;
    assign file_wr_data_o     = q.file_data;
    assign wdt_clear_o        = q.wdt_clr;
    assign osc_stop_o         = q.state == sse_pkg::SSE_HALT;
    assign acc_o              = q.acc;
    assign carry_o            = q.carry;
    assign digit_carry_flag_o = q.digit_carry_flag;
    assign zero_o             = q.zero;
    assign timeout_flag_o     = q.timeout_flag;
    assign power_down_flag_o  = q.power_down_flag;
    assign reg_rdata_o        = q.rd_data;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    sleep_pd_clear_a: assert property (exec_sleep |=> !power_down_flag_o)
        else $error("Sleep did not clear the power-down flag.");

    sleep_to_set_a: assert property (exec_sleep |=> timeout_flag_o)
        else $error("Sleep did not set the timeout flag.");

    sleep_keeps_alu_a: assert property (exec_sleep && !reg_wr_i |=>
        $stable(carry_o) && $stable(zero_o) && $stable(digit_carry_flag_o) && $stable(acc_o))
        else $error("Sleep changed an arithmetic flag or the accumulator.");

    wdt_clear_pulse_a: assert property (exec_sleep |=> wdt_clear_o ##1 (!wdt_clear_o || !clk_en_i))
        else $error("Watchdog clear was not a single pulse after sleep.");

    halt_entry_a: assert property (exec_sleep |=> osc_stop_o && !instr_ready_o)
        else $error("Core did not halt after sleep.");

    halt_hold_a: assert property (osc_stop_o && !wake_i |=> osc_stop_o && !file_wr_o)
        else $error("Core left the halted state without a wake-up.");

    literal_minus_acc_op_result_a: assert property (exec_subl |=> acc_o == 8'($past(literal) - $past(q.acc)))
        else $error("Literal subtract stored a wrong accumulator value.");

    reg_minus_acc_op_acc_a: assert property (exec_subf && !dest_file |=>
        acc_o == 8'($past(file_rd_data_i) - $past(q.acc)) && !file_wr_o)
        else $error("Register subtract to the accumulator went wrong.");

    reg_minus_acc_op_file_a: assert property (exec_subf && dest_file && !reg_wr_i |=> file_wr_o && $stable(acc_o) &&
        file_wr_addr_o == $past(file_addr) && file_wr_data_o == 8'($past(file_rd_data_i) - $past(q.acc)))
        else $error("Register subtract write-back went wrong.");

    sub_carry_a: assert property (exec_subl || exec_subf |=>
        carry_o == ($past(sub_arg) >= $past(q.acc)))
        else $error("Carry does not act as an inverted borrow.");

    sub_zero_carry_a: assert property ((exec_subl || exec_subf) && sub_arg == q.acc |=>
        carry_o && zero_o)
        else $error("Zero difference did not set carry and zero.");

    sub_underflow_a: assert property ((exec_subl || exec_subf) && sub_arg < q.acc |=>
        !carry_o && !zero_o)
        else $error("Underflow did not clear carry.");

    sub_dc_a: assert property (exec_subl || exec_subf |=>
        digit_carry_flag_o == ($past(sub_arg[3:0]) >= $past(q.acc[3:0])))
        else $error("Digit carry is not the low nibble inverted borrow.");

    sleep_seen_c: cover property (exec_sleep ##[1:20] (wake_i && osc_stop_o));
    subl_neg_c: cover property (exec_subl && sub_arg < q.acc);
    subf_file_c: cover property (exec_subf && dest_file);
    subf_zero_c: cover property (exec_subf && !dest_file && sub_arg == q.acc);

endmodule
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [7:0] acc;
        logic       c, dc, z, to, pd, wr, wdt, stop;
        logic [6:0] wa;
        logic [7:0] wd;
    } sse_exp_t;

    logic        ref_clk_i, reset_i, clk_en_i, instr_valid_i, wake_i, reg_wr_i, reg_rd_i;
    logic [13:0] instr_i;
    logic [7:0]  file_rd_data_i, reg_wdata_i, reg_rdata_o, acc_o, file_wr_data_o, w, r;
    logic [1:0]  reg_addr_i;
    logic [6:0]  file_rd_addr_o, file_wr_addr_o;
    logic        instr_ready_o, file_wr_o, wdt_clear_o, osc_stop_o, carry_o, digit_carry_flag_o, zero_o;
    logic        timeout_flag_o, power_down_flag_o, c, dc, z, to, pd;
    logic        took = 1'b0;
    logic        rtook = 1'b0;
    int          fail_count, n_checks, n, i;
    integer      seed;
    sse_exp_t    eq[$];
    sse_exp_t    e, s;
    logic [7:0]  rq[$];
    logic [7:0]  w_tab[5] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h10};
    logic [7:0]  k_tab[5] = '{8'h02, 8'h02, 8'h02, 8'h10, 8'h0F};
    logic [13:0] nop_tab[4] = '{14'h3400, 14'h3E00, 14'h0300, 14'h0062};

    sse_core i_dut (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o), .wake_i(wake_i),
        .file_rd_addr_o(file_rd_addr_o), .file_rd_data_i(file_rd_data_i), .file_wr_o(file_wr_o),
        .file_wr_addr_o(file_wr_addr_o), .file_wr_data_o(file_wr_data_o), .wdt_clear_o(wdt_clear_o),
        .osc_stop_o(osc_stop_o), .acc_o(acc_o), .carry_o(carry_o), .digit_carry_flag_o(digit_carry_flag_o),
        .zero_o(zero_o), .timeout_flag_o(timeout_flag_o), .power_down_flag_o(power_down_flag_o),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic complete_run;
        if (fail_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] stat();
        return {3'b000, to, pd, z, dc, c};
    endfunction

    task automatic model_reset;
        w = 8'h00;
        {c, dc, z} = 3'b000;
        {to, pd} = 2'b11;
    endtask

    // Offers one instruction and notes the result the core must show one cycle later.
    task automatic exec(input logic [13:0] ins, input logic [7:0] f);
        logic [7:0] m;
        logic [7:0] res;
        sse_exp_t   x;
        @(posedge ref_clk_i);
        instr_i <= ins;
        instr_valid_i <= 1'b1;
        file_rd_data_i <= f;
        x = '0;
        m = (ins[13:8] == 6'h02) ? f : ins[7:0];
        if (ins == 14'h0063) begin
            pd = 1'b0;
            to = 1'b1;
            x.wdt = 1'b1;
            x.stop = 1'b1;
        end else if (ins[13:9] == 5'h1E || ins[13:8] == 6'h02) begin
            res = m - w;
            c = m >= w;
            dc = m[3:0] >= w[3:0];
            z = res == 8'h00;
            if (ins[13:8] == 6'h02 && ins[7]) begin
                x.wr = 1'b1;
                x.wa = ins[6:0];
                x.wd = res;
            end else begin
                w = res;
            end
        end
        {x.acc, x.c, x.dc, x.z, x.to, x.pd} = {w, c, dc, z, to, pd};
        eq.push_back(x);
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        instr_valid_i <= 1'b0;
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        if (a == 2'h0)
            w = d;
        if (a == 2'h1)
            {z, dc, c} = d[2:0];
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        instr_valid_i <= 1'b0;
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        rq.push_back(exp);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
    endtask

    always @(posedge ref_clk_i) begin
        took <= instr_valid_i & instr_ready_o & clk_en_i & ~reset_i;
        rtook <= reg_rd_i & clk_en_i & ~reset_i;
    end

    always @(negedge ref_clk_i) begin
        if (took) begin
            e = '1;
            if (eq.size() > 0)
                e = eq.pop_front();
            s = {acc_o, carry_o, digit_carry_flag_o, zero_o, timeout_flag_o, power_down_flag_o, file_wr_o,
                 wdt_clear_o, osc_stop_o, file_wr_addr_o, file_wr_data_o};
            if (!e.wr) begin
                s.wa = e.wa;
                s.wd = e.wd;
            end
            chk(s, e);
        end else if (!reset_i) begin
            chk({file_wr_o, wdt_clear_o}, 2'b00);
        end
        if (rtook) begin
            r = 8'hXX;
            if (rq.size() > 0)
                r = rq.pop_front();
            chk(reg_rdata_o, r);
        end else if (!reset_i) begin
            chk(reg_rdata_o, 8'h00);
        end
    end

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        fail_count++;
        complete_run();
    end

    initial begin
        seed = 32'heef7_67ff;
        {clk_en_i, instr_valid_i, wake_i, reg_wr_i, reg_rd_i} = 5'b10000;
        instr_i = 14'h0000;
        file_rd_data_i = 8'h00;
        reg_wdata_i = 8'h00;
        reg_addr_i = 2'h0;
        reset_i = 1'b1;
        model_reset();
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rd(2'h1, 8'h18);
        wr(2'h1, 8'hFF);
        wr(2'h2, 8'hFF);
        rd(2'h1, stat());
        rd(2'h2, 8'h00);
        rd(2'h3, 8'h00);
        for (i = 0; i < 5; i++) begin
            wr(2'h0, w_tab[i]);
            exec({6'h3C, k_tab[i]}, 8'hA5);
            wr(2'h0, w_tab[i]);
            exec({6'h02, 1'b1, {7{i[0]}}}, k_tab[i]);
            exec({6'h02, 1'b0, 7'h15}, k_tab[i]);
        end
        for (i = 0; i < 4; i++)
            exec(nop_tab[i], 8'h33);
        // A frozen cycle must not take the offered subtract.
        @(posedge ref_clk_i);
        clk_en_i <= 1'b0;
        instr_i <= 14'h3C77;
        instr_valid_i <= 1'b1;
        @(posedge ref_clk_i);
        clk_en_i <= 1'b1;
        instr_valid_i <= 1'b0;
        rd(2'h0, w);
        for (i = 0; i < 60; i++) begin
            n = $random(seed);
            if (n[3])
                wr(2'h0, 8'($random(seed)));
            if (n[0])
                exec({5'h1E, n[1], 8'($random(seed))}, 8'($random(seed)));
            else
                exec({6'h02, n[2], 7'($random(seed))}, 8'($random(seed)));
        end
        exec(14'h0063, 8'h00);
        repeat (3) begin
            @(posedge ref_clk_i);
            instr_i <= 14'h3C55;
            instr_valid_i <= 1'b1;
            #1;
            chk({instr_ready_o, osc_stop_o}, 2'b01);
        end
        rd(2'h2, 8'h01);
        rd(2'h1, stat());
        @(posedge ref_clk_i);
        wake_i <= 1'b1;
        n = 0;
        while (instr_ready_o !== 1'b1 && n < 10) begin
            @(posedge ref_clk_i);
            n++;
        end
        wake_i <= 1'b0;
        if (n == 10) begin
            fail_count++;
            complete_run();
        end
        rd(2'h0, w);
        wr(2'h0, 8'h00);
        exec(14'h0063, 8'h00);
        exec({6'h3C, 8'h00}, 8'h00);
        @(posedge ref_clk_i);
        instr_valid_i <= 1'b0;
        reset_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        eq.delete();
        model_reset();
        rd(2'h1, 8'h18);
        rd(2'h2, 8'h00);
        rd(2'h0, 8'h00);
        repeat (3) @(posedge ref_clk_i);
        chk(eq.size() + rq.size(), 0);
        complete_run();
    end
endmodule
`default_nettype wire
